// File: src/lih_unit.sv
// Purpose: Level interrupt holding unit with Avalon-MM register slave
// Assumes: Source lines asynchronous to clk_sys
// Notes: Holding bit n appears at data bit 15-n
`timescale 1ns/10ps
`include "lih_params.svh"
module lih_unit
  import lih_pkg::*;
#(
  parameter int RTC_CYC = `LIH_RTC_CYC,
  parameter int POLL_CYC = `LIH_POLL_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] micro_src,
  input wire logic [15:0] macro_src,
  input wire logic [2:0] loop_irq,
  input wire logic [15:0] statmode_set,
  output logic [15:0] ctl_out,
  output logic fetch_defer,
  output logic [1:0] svc_kind,
  output logic irq
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [15:0] mic_s1_r, mic_s2_r, mac_s1_r, mac_s2_r, set_s1_r, set_s2_r;
  logic [2:0] loop_s1_r, loop_s2_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mic_s1_r <= 16'h0000;
      mic_s2_r <= 16'h0000;
      mac_s1_r <= 16'h0000;
      mac_s2_r <= 16'h0000;
      set_s1_r <= 16'h0000;
      set_s2_r <= 16'h0000;
      loop_s1_r <= 3'h0;
      loop_s2_r <= 3'h0;
    end else begin
      mic_s1_r <= micro_src;
      mic_s2_r <= mic_s1_r;
      mac_s1_r <= macro_src;
      mac_s2_r <= mac_s1_r;
      set_s1_r <= statmode_set;
      set_s2_r <= set_s1_r;
      loop_s1_r <= loop_irq;
      loop_s2_r <= loop_s1_r;
    end
  end

  // ************************************************************
  // Real-time clock
  // ************************************************************
  logic [31:0] rtc_cnt_r;
  logic [15:0] rtc_div_r, rtc_limit_r;
  logic rtc_micro_r, rtc_macro_r;
  logic rtc_tick;
  logic [31:0] rtc_cnt_nxt;
  logic [15:0] rtc_div_nxt;
  assign rtc_tick = (rtc_cnt_r == 32'(RTC_CYC - 1));
  assign rtc_cnt_nxt = rtc_tick ? 32'h0 : rtc_cnt_r + 32'h1;
  assign rtc_div_nxt = (rtc_div_r + 16'h1 >= rtc_limit_r) ? 16'h0 : rtc_div_r + 16'h1;
  // Clock lines are level: micro stays up until the next tick drops it, macro until the divider wraps
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rtc_cnt_r <= 32'h0;
      rtc_div_r <= 16'h0;
      rtc_micro_r <= 1'b0;
      rtc_macro_r <= 1'b0;
    end else begin
      rtc_cnt_r <= rtc_cnt_nxt;
      if (rtc_tick) begin
        rtc_micro_r <= ~rtc_micro_r;
        rtc_div_r <= rtc_div_nxt;
        if (rtc_div_nxt == 16'h0) begin
          rtc_macro_r <= ~rtc_macro_r;
        end
      end
    end
  end

  // ************************************************************
  // Source wiring into the holding words
  // ************************************************************
  logic [15:0] micro_lines, macro_lines;
  // Left-numbered position n is data bit 15-n
  always_comb begin
    micro_lines = mic_s2_r;
    micro_lines[15-`LIH_BIT_LOOP_A] = loop_s2_r[0];
    micro_lines[15-`LIH_BIT_LOOP_B] = loop_s2_r[1];
    micro_lines[15-`LIH_BIT_CLOCK] = rtc_micro_r;
    micro_lines = micro_lines & `LIH_MICRO_VALID;
    macro_lines = mac_s2_r;
    macro_lines[15-`LIH_BIT_LOOP_A] = loop_s2_r[0];
    macro_lines[15-`LIH_BIT_LOOP_B] = loop_s2_r[1];
    macro_lines[15-`LIH_BIT_LOOP_C] = loop_s2_r[2];
    macro_lines[15-`LIH_BIT_CLOCK] = rtc_macro_r;
    macro_lines = macro_lines & `LIH_MACRO_VALID;
  end

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic wait_r, wreq_r;
  logic acc, rd_fire, wr_fire;
  logic hit_mih, hit_mah, hit_mim, hit_mam, hit_enc, hit_sm, hit_lim, hit_ist, hit_imk, hit_ctl;
  // Two wait states: take and capture, then answer from flops
  assign acc = (avs_read | avs_write) & ~wait_r & wreq_r;
  assign rd_fire = avs_read & wait_r;
  assign wr_fire = avs_write & ~wreq_r;
  assign hit_mih = avs_address == `LIH_OFF_MICRO_HOLD;
  assign hit_mah = avs_address == `LIH_OFF_MACRO_HOLD;
  assign hit_mim = avs_address == `LIH_OFF_MICRO_MASK;
  assign hit_mam = avs_address == `LIH_OFF_MACRO_MASK;
  assign hit_enc = avs_address == `LIH_OFF_ENCODE;
  assign hit_sm = avs_address == `LIH_OFF_STATMODE;
  assign hit_lim = avs_address == `LIH_OFF_RTC_LIMIT;
  assign hit_ist = avs_address == `LIH_OFF_IRQ_STAT;
  assign hit_imk = avs_address == `LIH_OFF_IRQ_MASK;
  assign hit_ctl = avs_address == `LIH_OFF_CTRL;
  logic [15:0] wd16;
  assign wd16 = avs_writedata[15:0];
  logic we_lo;
  assign we_lo = wr_fire & (&avs_byteenable[1:0]);

  // ************************************************************
  // Holding registers, captured by the read of each
  // ************************************************************
  logic [15:0] micro_interrupt_hold_r, macro_interrupt_hold_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      micro_interrupt_hold_r <= 16'h0000;
      macro_interrupt_hold_r <= 16'h0000;
    end else begin
      // Capture on the read's first edge so the answer is stable
      if (acc & avs_read & (hit_mih | hit_enc)) begin
        micro_interrupt_hold_r <= micro_lines;
      end
      if (acc & avs_read & (hit_mah | hit_enc)) begin
        macro_interrupt_hold_r <= macro_lines;
      end
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  logic [15:0] micro_mask_r, macro_mask_r, statmode_r, irq_mask_r;
  logic [3:0] irq_stat_r;
  logic int_en_r, fetch_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      micro_mask_r <= `LIH_RST_MASK;
      macro_mask_r <= `LIH_RST_MASK;
      rtc_limit_r <= `LIH_RST_LIMIT;
      int_en_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      if (we_lo & hit_mim) begin
        micro_mask_r <= wd16;
      end
      if (we_lo & hit_mam) begin
        macro_mask_r <= wd16;
      end
      if (we_lo & hit_lim) begin
        rtc_limit_r <= (wd16 == 16'h0) ? 16'h1 : wd16;
      end
      if (we_lo & hit_ctl) begin
        int_en_r <= wd16[0];
        fetch_r <= wd16[1];
      end else begin
        fetch_r <= 1'b0;
      end
    end
  end

  // External set wins over a same-cycle program clear
  logic [15:0] statmode_nxt;
  assign statmode_nxt = ((we_lo & hit_sm) ? wd16 : statmode_r) | set_s2_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      statmode_r <= 16'h0000;
      ctl_out <= 16'h0000;
    end else begin
      statmode_r <= statmode_nxt;
      ctl_out <= statmode_nxt;
    end
  end

  // ************************************************************
  // Priority encoders and service selection
  // ************************************************************
  logic mic_act, mac_act;
  logic [3:0] mic_num, mac_num;
  lih_prio_enc #(.W(16)) u_enc_micro (
    .hold(micro_interrupt_hold_r),
    .mask(micro_mask_r),
    .active(mic_act),
    .num(mic_num)
  );
  lih_prio_enc #(.W(16)) u_enc_macro (
    .hold(macro_interrupt_hold_r),
    .mask(macro_mask_r),
    .active(mac_act),
    .num(mac_num)
  );
  lih_svc_t svc;
  assign svc = mic_act ? LIH_SVC_MICRO : (mac_act ? LIH_SVC_MACRO : LIH_SVC_NONE);

  // ************************************************************
  // Poll watchdog and events
  // ************************************************************
  logic [31:0] poll_cnt_r;
  logic poll_late, poll_seen;
  assign poll_seen = acc & avs_read & (hit_mih | hit_mah | hit_enc);
  assign poll_late = (poll_cnt_r == 32'(POLL_CYC - 1)) & ~poll_seen;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      poll_cnt_r <= 32'h0;
    end else if (poll_seen | poll_late) begin
      poll_cnt_r <= 32'h0;
    end else begin
      poll_cnt_r <= poll_cnt_r + 32'h1;
    end
  end

  logic [3:0] ev, irq_stat_nxt;
  assign ev[`LIH_EV_MICRO] = |micro_lines;
  assign ev[`LIH_EV_MACRO] = |macro_lines;
  assign ev[`LIH_EV_POLL] = poll_late;
  assign ev[`LIH_EV_LOST] = rtc_tick & rtc_macro_r & rtc_div_nxt == 16'h0;
  assign irq_stat_nxt = (irq_stat_r & ~((we_lo & hit_ist) ? wd16[3:0] : 4'h0)) | ev;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= 4'h0;
      irq_mask_r <= `LIH_RST_MASK;
      irq <= 1'b0;
      fetch_defer <= 1'b0;
      svc_kind <= 2'b00;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (we_lo & hit_imk) begin
        irq_mask_r <= wd16;
      end
      irq <= |(irq_stat_nxt & irq_mask_r[3:0]);
      // Macro only defers fetch when firmware asks and enabled
      fetch_defer <= fetch_r & int_en_r & mac_act & ~mic_act;
      svc_kind <= svc;
    end
  end

  // ************************************************************
  // Read data and handshake
  // ************************************************************
  logic [15:0] rd_mux;
  assign rd_mux = hit_mih ? micro_interrupt_hold_r : hit_mah ? macro_interrupt_hold_r :
    hit_mim ? micro_mask_r : hit_mam ? macro_mask_r :
    hit_enc ? {1'b0, mac_act, mac_num, svc, mic_act, mic_num, 3'h0} :
    hit_sm ? statmode_r : hit_lim ? rtc_limit_r :
    hit_ist ? {12'h0, irq_stat_r} : hit_imk ? irq_mask_r :
    hit_ctl ? {14'h0, fetch_r, int_en_r} : 16'h0000;
  logic [31:0] rdata_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_r <= 1'b0;
      wreq_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= acc;
      wreq_r <= ~wait_r;
      rdata_r <= rd_fire ? {16'h0, rd_mux} : 32'h0;
    end
  end
  // Registered answer costs a cycle but keeps both outputs glitch-free
  assign avs_waitrequest = wreq_r;
  assign avs_readdata = rdata_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_hold_capture: assert property (
    acc & avs_read & hit_mih |=> micro_interrupt_hold_r == $past(micro_lines))
    else $error("micro hold not captured");
  a_hold_stable: assert property (
    !(acc & avs_read & (hit_mah | hit_enc)) |=> $stable(macro_interrupt_hold_r))
    else $error("macro hold moved");
  a_unassigned_zero: assert property (
    (micro_interrupt_hold_r & ~`LIH_MICRO_VALID) == 16'h0)
    else $error("unassigned micro bit set");
  a_macro_unassigned: assert property (
    (macro_interrupt_hold_r & ~`LIH_MACRO_VALID) == 16'h0)
    else $error("unassigned macro bit set");
  a_micro_first: assert property (
    mic_act |=> svc_kind == LIH_SVC_MICRO)
    else $error("micro not first");
  a_svc_idle: assert property (
    !mic_act & !mac_act |=> svc_kind == LIH_SVC_NONE)
    else $error("service without request");
  a_statmode_set: assert property (
    |set_s2_r |=> (statmode_r & $past(set_s2_r)) == $past(set_s2_r))
    else $error("set lost");
  a_ctl_follow: assert property (
    ##1 ctl_out == statmode_r)
    else $error("control out differs");
  a_defer_gate: assert property (
    !int_en_r |=> !fetch_defer)
    else $error("defer while disabled");
  a_loop_both: assert property (
    micro_lines[15] == macro_lines[15])
    else $error("loop wiring differs");
  a_poll_bound: assert property (
    poll_cnt_r < 32'(POLL_CYC))
    else $error("poll counter overran");
  a_answer_one: assert property (
    acc |-> ##2 !avs_waitrequest)
    else $error("answer late");
  a_micro_top: assert property (
    mic_act |-> ((micro_interrupt_hold_r & micro_mask_r) >> (4'hf - mic_num)) == 16'h1)
    else $error("micro number not top");
  a_macro_top: assert property (
    mac_act |-> ((macro_interrupt_hold_r & macro_mask_r) >> (4'hf - mac_num)) == 16'h1)
    else $error("macro number not top");
  c_micro_svc: cover property (svc_kind == LIH_SVC_MICRO);
  c_macro_defer: cover property (fetch_defer);
  c_poll_late: cover property (poll_late);
  c_rtc_tick: cover property (rtc_tick);
  c_encode_read: cover property (acc & avs_read & hit_enc);
endmodule : lih_unit

// File: src/lih_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit Avalon-MM word addressing in bytes
// Notes: Holding bit n sits at data bit 15-n, so bit zero is leftmost
`ifndef LIH_PARAMS_SVH
`define LIH_PARAMS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define LIH_OFF_MICRO_HOLD 6'h00
`define LIH_OFF_MACRO_HOLD 6'h04
`define LIH_OFF_MICRO_MASK 6'h08
`define LIH_OFF_MACRO_MASK 6'h0c
`define LIH_OFF_ENCODE 6'h10
`define LIH_OFF_STATMODE 6'h14
`define LIH_OFF_RTC_LIMIT 6'h18
`define LIH_OFF_IRQ_STAT 6'h1c
`define LIH_OFF_IRQ_MASK 6'h20
`define LIH_OFF_CTRL 6'h24

// ************************************************************
// Fixed source assignment, holding bit numbers
// ************************************************************
`define LIH_MICRO_VALID 16'he99f
`define LIH_MACRO_VALID 16'hfffd
`define LIH_BIT_LOOP_A 4'h0
`define LIH_BIT_CONSOLE 4'h1
`define LIH_BIT_LOOP_B 4'h2
`define LIH_BIT_SUBSYS3 4'h3
`define LIH_BIT_PRINTER 4'h4
`define LIH_BIT_CASSETTE 4'h7
`define LIH_BIT_CLOCK 4'h8
`define LIH_BIT_READER 4'hb
`define LIH_BIT_LOOP_C 4'hc

// ************************************************************
// Interrupt status bits and reset values
// ************************************************************
`define LIH_EV_MICRO 0
`define LIH_EV_MACRO 1
`define LIH_EV_POLL 2
`define LIH_EV_LOST 3
`define LIH_RST_LIMIT 16'h0001
`define LIH_RST_MASK 16'h0000

// ************************************************************
// Timing
// ************************************************************
`define LIH_CLK_NS 10
`define LIH_RTC_PERIOD_NS 3300000
`define LIH_POLL_LIMIT_NS 20000
`define LIH_POLL_CYC (`LIH_POLL_LIMIT_NS / `LIH_CLK_NS)
`define LIH_RTC_CYC (`LIH_RTC_PERIOD_NS / `LIH_CLK_NS)
`endif

// File: src/lih_pkg.sv
// Purpose: Types shared by the holding unit
// Assumes: Nothing beyond the params header
// Notes: Service selection kinds
package lih_pkg;
  typedef enum logic [1:0] {
    LIH_SVC_NONE = 2'b00,
    LIH_SVC_MICRO = 2'b01,
    LIH_SVC_MACRO = 2'b10
  } lih_svc_t;
endpackage : lih_pkg

// File: src/lih_prio_enc.sv
// Purpose: Leftmost-first priority encoder over one masked holding word
// Assumes: Holding bit n is data bit 15-n
// Notes: Purely combinational
`timescale 1ns/10ps
module lih_prio_enc #(
  parameter int W = 16
) (
  input wire logic [W-1:0] hold,
  input wire logic [W-1:0] mask,
  output logic active,
  output logic [3:0] num
);
  logic [W-1:0] live;
  assign live = hold & mask;
  assign active = |live;
  always_comb begin
    num = 4'h0;
    for (int i = W - 1; i >= 0; i--) begin
      if (live[W-1-i]) begin
        num = 4'(i);
      end
    end
  end
endmodule : lih_prio_enc

// File: dv/lih_periph_model.sv
// Purpose: Peripheral side model driving level interrupt lines
// Assumes: Bench states wanted lines and pulses done once serviced
// Notes: A raised line never drops before done, so no request is lost
`timescale 1ns/10ps
module lih_periph_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] want_micro,
  input wire logic [15:0] want_macro,
  input wire logic done,
  output logic [15:0] micro_src,
  output logic [15:0] macro_src
);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      micro_src <= 16'h0000;
      macro_src <= 16'h0000;
    end else begin
      // Level held until serviced, both kinds may rise together
      micro_src <= want_micro | (micro_src & {16{!done}});
      macro_src <= want_macro | (macro_src & {16{!done}});
    end
  end
endmodule : lih_periph_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the level interrupt holding unit
// Assumes: Lines reach the holds within 3 edges of the pin
// Notes: Clock holding bit is masked out where it would race a check
`timescale 1ns/10ps
`include "lih_params.svh"
module tb_top
  import lih_pkg::*;
;
  localparam int POLL = 100;
  localparam int RTC = 50;
  localparam logic [31:0] NCLK = 32'hffffff7f;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [15:0] LMI [3] = '{16'h8000, 16'h2000, 16'h0000};
  localparam logic [15:0] LMA [3] = '{16'h8000, 16'h2000, 16'h0008};
  logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, fetch_defer, irq, done;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [15:0] micro_src, macro_src, statmode_set, ctl_out, want_micro, want_macro;
  logic [2:0] loop_irq;
  logic [1:0] svc_kind;
  int errors, samples_checked, cyc_cnt;

  lih_unit #(.RTC_CYC(RTC), .POLL_CYC(POLL)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .micro_src(micro_src), .macro_src(macro_src), .loop_irq(loop_irq),
    .statmode_set(statmode_set), .ctl_out(ctl_out), .fetch_defer(fetch_defer),
    .svc_kind(svc_kind), .irq(irq));
  lih_periph_model u_per (.clk_sys(clk_sys), .rstn(rstn), .want_micro(want_micro),
    .want_macro(want_macro), .done(done), .micro_src(micro_src), .macro_src(macro_src));

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end

  task end_sim();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      errors++;
      end_sim();
    end
  end

  // ****************************************
  // Bus, lines and checks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Request held until the edge that sees waitrequest low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e, "read");
  endtask : rdchk

  task lines(input logic [15:0] mi, input logic [15:0] ma);
    want_micro <= mi;
    want_macro <= ma;
    done <= 1'b1;
    @(posedge clk_sys);
    done <= 1'b0;
    cyc(5);
  endtask : lines

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    rdchk(`LIH_OFF_MICRO_MASK, ALL, 32'h0);
    rdchk(`LIH_OFF_MACRO_MASK, ALL, 32'h0);
    avs_byteenable <= 4'hc;
    bus(1'b1, `LIH_OFF_MICRO_MASK, 32'hffff);
    avs_byteenable <= 4'hf;
    rdchk(`LIH_OFF_MICRO_MASK, ALL, 32'h0);
    rdchk(`LIH_OFF_RTC_LIMIT, ALL, 32'h1);
    bus(1'b1, 6'h3c, 32'hffff);
    rdchk(6'h3c, ALL, 32'h0);
    bus(1'b1, `LIH_OFF_MICRO_HOLD, 32'hffff);
    rdchk(`LIH_OFF_MICRO_HOLD, NCLK, 32'h0);
  endtask : t_reset

  task t_levels();
    lines(16'h5fff, 16'h5fff);
    rdchk(`LIH_OFF_MICRO_HOLD, NCLK, 32'h491f);
    rdchk(`LIH_OFF_MACRO_HOLD, NCLK, 32'h5f75);
    lines(16'h0000, 16'h0000);
    rdchk(`LIH_OFF_MICRO_HOLD, NCLK, 32'h0);
    rdchk(`LIH_OFF_MACRO_HOLD, NCLK, 32'h0);
  endtask : t_levels

  task t_loop();
    for (int i = 0; i < 3; i++) begin
      loop_irq <= 3'b001 << i;
      cyc(5);
      rdchk(`LIH_OFF_MICRO_HOLD, NCLK, {16'h0, LMI[i]});
      rdchk(`LIH_OFF_MACRO_HOLD, NCLK, {16'h0, LMA[i]});
    end
    loop_irq <= 3'b000;
  endtask : t_loop

  task t_prio();
    bus(1'b1, `LIH_OFF_MICRO_MASK, 32'hf77f);
    bus(1'b1, `LIH_OFF_MACRO_MASK, 32'hff7f);
    lines(16'h0818, 16'h1400);
    bus(1'b0, `LIH_OFF_ENCODE, 32'h0);
    chk({25'h0, rd[9:3]}, {25'h0, 7'b0111011}, "encode micro");
    cyc(3);
    chk({30'h0, svc_kind}, {30'h0, LIH_SVC_MICRO}, "svc micro");
    bus(1'b1, `LIH_OFF_MICRO_MASK, 32'hff7f);
    lines(16'h1000, 16'h1400);
    bus(1'b0, `LIH_OFF_ENCODE, 32'h0);
    chk({29'h0, rd[9:7]}, {29'h0, 3'b100}, "encode macro");
    chk({27'h0, rd[14:10]}, {27'h0, 5'b10011}, "encode macro num");
    cyc(3);
    chk({30'h0, svc_kind}, {30'h0, LIH_SVC_MACRO}, "svc macro");
  endtask : t_prio

  task t_statmode();
    bus(1'b1, `LIH_OFF_STATMODE, 32'h00a5);
    cyc(3);
    chk({16'h0, ctl_out}, 32'h00a5, "ctl");
    statmode_set <= 16'h0100;
    cyc(2);
    statmode_set <= 16'h0000;
    cyc(5);
    rdchk(`LIH_OFF_STATMODE, 32'hffff, 32'h01a5);
    chk({16'h0, ctl_out}, 32'h01a5, "ctl set");
    bus(1'b1, `LIH_OFF_STATMODE, 32'h0);
    cyc(3);
    chk({16'h0, ctl_out}, 32'h0, "ctl clear");
  endtask : t_statmode

  task t_defer();
    lines(16'h0000, 16'h1000);
    bus(1'b0, `LIH_OFF_ENCODE, 32'h0);
    cyc(3);
    chk({31'h0, fetch_defer}, 32'h0, "no forced flow");
    // Defer stands one cycle: looked at on the edge that ends it
    bus(1'b1, `LIH_OFF_CTRL, 32'h3);
    cyc(2);
    chk({31'h0, fetch_defer}, 32'h1, "defer");
    bus(1'b1, `LIH_OFF_CTRL, 32'h2);
    cyc(2);
    chk({31'h0, fetch_defer}, 32'h0, "disabled");
    bus(1'b1, `LIH_OFF_CTRL, 32'h0);
    lines(16'h0000, 16'h0000);
  endtask : t_defer

  task t_irq();
    bus(1'b1, `LIH_OFF_IRQ_MASK, 32'h4);
    bus(1'b0, `LIH_OFF_MICRO_HOLD, 32'h0);
    bus(1'b1, `LIH_OFF_IRQ_STAT, 32'hf);
    repeat (4) begin
      cyc(40);
      bus(1'b0, `LIH_OFF_MICRO_HOLD, 32'h0);
    end
    rdchk(`LIH_OFF_IRQ_STAT, 32'h4, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq quiet");
    cyc(POLL + 20);
    rdchk(`LIH_OFF_IRQ_STAT, 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1, "irq gap");
    bus(1'b1, `LIH_OFF_IRQ_MASK, 32'h0);
    cyc(3);
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b1, `LIH_OFF_IRQ_MASK, 32'h4);
    bus(1'b0, `LIH_OFF_MICRO_HOLD, 32'h0);
    bus(1'b1, `LIH_OFF_IRQ_STAT, 32'h4);
    cyc(3);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask : t_irq

  task t_rtc();
    int mt;
    int at;
    int t0;
    int ex;
    logic pm;
    logic pa;
    mt = 0;
    at = 0;
    bus(1'b1, `LIH_OFF_RTC_LIMIT, 32'h2);
    bus(1'b0, `LIH_OFF_MICRO_HOLD, 32'h0);
    pm = rd[7];
    bus(1'b0, `LIH_OFF_MACRO_HOLD, 32'h0);
    pa = rd[7];
    t0 = cyc_cnt;
    repeat (100) begin
      bus(1'b0, `LIH_OFF_MICRO_HOLD, 32'h0);
      mt += (rd[7] !== pm);
      pm = rd[7];
      bus(1'b0, `LIH_OFF_MACRO_HOLD, 32'h0);
      at += (rd[7] !== pa);
      pa = rd[7];
    end
    // Expected toggles from elapsed cycles, not from bus latency
    ex = (cyc_cnt - t0) / RTC;
    chk({31'h0, mt inside {[ex - 1:ex + 1]}}, 32'h1, "rtc micro ticks");
    chk({31'h0, at inside {[ex/2 - 1:ex/2 + 1]}}, 32'h1, "rtc macro ticks");
  endtask : t_rtc

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    loop_irq = 3'b000;
    statmode_set = 16'h0000;
    want_micro = 16'h0000;
    want_macro = 16'h0000;
    done = 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_levels();
    t_loop();
    t_prio();
    t_statmode();
    t_defer();
    t_irq();
    t_rtc();
    end_sim();
  end
endmodule : tb_top
